/* File: rtl/dacc_pkg.sv */
// constants and types for the dsp alu clear/compare/copy/decrement stage
package dacc_pkg;
	localparam logic [5:0] FIRST_HW_TAG = 6'h3e;
	localparam logic [7:0] OP_CLR_U = 8'h8d;
	localparam logic [7:0] OP_CLR_T = 8'h8e;
	localparam logic [7:0] OP_CLR_F = 8'h8f;
	localparam logic [7:0] OP_CMP = 8'h84;
	localparam logic [7:0] OP_CPX_U = 8'hd9;
	localparam logic [7:0] OP_CPX_T = 8'hda;
	localparam logic [7:0] OP_CPX_F = 8'hdb;
	localparam logic [7:0] OP_CPY_U = 8'hf9;
	localparam logic [7:0] OP_CPY_T = 8'hfa;
	localparam logic [7:0] OP_CPY_F = 8'hfb;
	localparam logic [7:0] OP_DX_U = 8'h89;
	localparam logic [7:0] OP_DX_T = 8'h8a;
	localparam logic [7:0] OP_DX_F = 8'h8b;
	localparam logic [7:0] OP_DY_U = 8'ha9;
	localparam logic [7:0] OP_DY_T = 8'haa;
	localparam logic [7:0] OP_DY_F = 8'hab;
	localparam int DEC_SEL_BIT = 13;
	localparam logic [7:0] GUARD_NEG = 8'hff;
	localparam logic [7:0] GUARD_POS = 8'h00;
	localparam logic [3:0] DST_ACC_ZERO = 4'h0;
	localparam logic [3:0] DST_ACC_ONE = 4'h1;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [31:0] DEC_ONE = 32'h0001_0000;
	typedef enum logic [1:0] {DACC_UNCOND, DACC_IF_TRUE, DACC_IF_FALSE} dacc_cond_t;
	typedef enum logic [2:0] {DACC_NONE, DACC_CLR, DACC_CMP, DACC_COPY, DACC_DEC} dacc_op_t;
endpackage

/* File: rtl/dacc_alu.sv */
// execution stage for clear, compare, copy and decrement
`timescale 1ns/1ns
module dacc_alu #(
	parameter int W = 32,
	parameter int GW = 8
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// instruction from decoder
	input wire logic i_valid,
	input wire logic [15:0] i_first_hw,
	input wire logic [15:0] i_second_hw,
	// operand registers from register file
	input wire logic [W-1:0] i_xbus_reg_zero,
	input wire logic [W-1:0] i_xbus_reg_one,
	input wire logic [W-1:0] i_ybus_reg_zero,
	input wire logic [W-1:0] i_ybus_reg_one,
	input wire logic [W-1:0] i_mul_reg_zero,
	input wire logic [W-1:0] i_mul_reg_one,
	input wire logic [W-1:0] i_acc_zero,
	input wire logic [W-1:0] i_acc_one,
	input wire logic [GW-1:0] i_acc_zero_guard,
	input wire logic [GW-1:0] i_acc_one_guard,
	// status register fields
	input wire logic [2:0] i_cond_sel,
	input wire logic i_cond_flag_bit,
	// condition-flag mapping supplied outside this block
	input wire logic i_cond_map,
	output logic [4:0] o_cond_map_in,
	// register write-back
	output logic o_wr_en,
	output logic [3:0] o_wr_dest,
	output logic [W-1:0] o_wr_data,
	output logic o_guard_wr_en,
	output logic [31:0] o_guard_data,
	// status flag update
	output logic o_flag_wr_en,
	output logic o_cond_flag_bit,
	output logic o_negative_flag,
	output logic o_zero_flag,
	output logic o_overflow_flag,
	output logic o_greater_flag,
	output logic [2:0] o_cond_sel_used
);
	// decode helper: maps second-halfword opcode to its operation
	function automatic dacc_pkg::dacc_op_t op_of(input logic [7:0] c);
		case (c)
			dacc_pkg::OP_CLR_U, dacc_pkg::OP_CLR_T, dacc_pkg::OP_CLR_F: op_of = dacc_pkg::DACC_CLR;
			dacc_pkg::OP_CMP: op_of = dacc_pkg::DACC_CMP;
			dacc_pkg::OP_CPX_U, dacc_pkg::OP_CPX_T, dacc_pkg::OP_CPX_F,
			dacc_pkg::OP_CPY_U, dacc_pkg::OP_CPY_T, dacc_pkg::OP_CPY_F: op_of = dacc_pkg::DACC_COPY;
			dacc_pkg::OP_DX_U, dacc_pkg::OP_DX_T, dacc_pkg::OP_DX_F,
			dacc_pkg::OP_DY_U, dacc_pkg::OP_DY_T, dacc_pkg::OP_DY_F: op_of = dacc_pkg::DACC_DEC;
			default: op_of = dacc_pkg::DACC_NONE;
		endcase
	endfunction

	// low two opcode bits give the condition form in every family here
	function automatic dacc_pkg::dacc_cond_t cond_of(input logic [7:0] c);
		case (c[1:0])
			2'h2: cond_of = dacc_pkg::DACC_IF_TRUE;
			2'h3: cond_of = dacc_pkg::DACC_IF_FALSE;
			default: cond_of = dacc_pkg::DACC_UNCOND;
		endcase
	endfunction

	// guard byte for a 32-bit source that has no guard bits of its own
	function automatic logic [GW-1:0] guard_of(input logic msb);
		guard_of = msb ? dacc_pkg::GUARD_NEG : dacc_pkg::GUARD_POS;
	endfunction

	// decoded instruction: operation, condition form and operand fields
	dacc_pkg::dacc_op_t op;
	dacc_pkg::dacc_cond_t cform;
	logic [1:0] fx;
	logic [1:0] fy;
	logic [3:0] dz;
	logic use_y;
	logic is_sub;

	// operands as selected, then as fed to the adder
	logic [W-1:0] s1x;
	logic [W-1:0] s2y;
	logic [GW-1:0] g1x;
	logic [GW-1:0] g2y;
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [GW-1:0] g1;
	logic [GW-1:0] g2;

	// 40-bit result split into word and guard byte, with its flags
	logic [W-1:0] dst;
	logic [GW-1:0] dstg;
	logic carry;
	logic borrow;
	logic ovf;
	logic neg;
	logic zero;
	logic gt;

	// execution gate: unconditional form, or condition met
	logic run;
	logic uncond;

	// write-back strobes, each paired with its next value
	logic wr_en_r;
	logic wr_en_nxt;
	logic gwr_r;
	logic gwr_nxt;
	logic fwr_r;
	logic fwr_nxt;

	// write-back payload
	logic [3:0] dest_r;
	logic [3:0] dest_nxt;
	logic [W-1:0] data_r;
	logic [W-1:0] data_nxt;
	logic [31:0] gdata_r;
	logic [31:0] gdata_nxt;

	// status flags and the select value they were made under
	logic [4:0] flags_r;
	logic [4:0] flags_nxt;
	logic [2:0] sel_r;
	logic [2:0] sel_nxt;

	// operand select and sign extension
	always_comb
	begin
		op = i_valid && (i_first_hw[15:10] == dacc_pkg::FIRST_HW_TAG) ?
			op_of(i_second_hw[15:8]) : dacc_pkg::DACC_NONE;
		cform = (op == dacc_pkg::DACC_CMP) ? dacc_pkg::DACC_UNCOND : cond_of(i_second_hw[15:8]);
		// operand fields sit at the same place in every form here
		fx = i_second_hw[7:6];
		fy = i_second_hw[5:4];
		dz = i_second_hw[3:0];
		case (fx)
			2'h0:
			begin
				s1x = i_xbus_reg_zero;
				g1x = guard_of(i_xbus_reg_zero[W-1]);
			end
			2'h1:
			begin
				s1x = i_xbus_reg_one;
				g1x = guard_of(i_xbus_reg_one[W-1]);
			end
			2'h2:
			begin
				s1x = i_acc_zero;
				g1x = i_acc_zero_guard; // accumulators bring their own guard
			end
			default:
			begin
				s1x = i_acc_one;
				g1x = i_acc_one_guard;
			end
		endcase
		case (fy)
			2'h0: s2y = i_ybus_reg_zero;
			2'h1: s2y = i_ybus_reg_one;
			2'h2: s2y = i_mul_reg_zero;
			default: s2y = i_mul_reg_one;
		endcase
		g2y = guard_of(s2y[W-1]);
		use_y = i_second_hw[dacc_pkg::DEC_SEL_BIT];
		// defaults: plain addition of the selected operands
		is_sub = 1'b0;
		s1 = s1x;
		g1 = g1x;
		s2 = s2y;
		g2 = g2y;
		// copy adds zero to one side so its flags come out as for addition
		case (op)
			dacc_pkg::DACC_CMP: is_sub = 1'b1;
			dacc_pkg::DACC_COPY:
			begin
				// the unused side reads zero so the sum is the source itself
				if (use_y)
				begin
					s1 = '0;
					g1 = '0;
				end
				else
				begin
					s2 = '0;
					g2 = '0;
				end
			end
			dacc_pkg::DACC_DEC:
			begin
				is_sub = 1'b1;
				// y form takes its operand from the second-source field
				if (use_y)
				begin
					s1 = s2y;
					g1 = g2y;
				end
				s2 = dacc_pkg::DEC_ONE;
				g2 = '0;
			end
			default: is_sub = 1'b0;
		endcase
	end

	// 40-bit arithmetic: word result, carry from sign bits, guard byte
	always_comb
	begin
		dst = is_sub ? s1 - s2 : s1 + s2;
		if (is_sub)
			carry = ((s1[W-1] | ~s2[W-1]) & ~dst[W-1]) | (s1[W-1] & ~s2[W-1]);
		else
			carry = ((s1[W-1] | s2[W-1]) & ~dst[W-1]) | (s1[W-1] & s2[W-1]);
		// borrow into the guard byte is the inverse of the word carry
		borrow = ~carry;
		dstg = is_sub ? g1 - g2 - {{(GW-1){1'b0}}, borrow} : g1 + g2 + {{(GW-1){1'b0}}, carry};
		// overflow when the guard byte no longer equals the sign extension
		ovf = (dstg != {GW{dst[W-1]}});
		neg = dstg[GW-1];
		zero = (dst == '0) && (dstg == '0);
		gt = ~neg & ~zero;
		// decrement keeps only the upper halfword; its negative, zero and greater flags ignore the guard byte
		if (op == dacc_pkg::DACC_DEC)
		begin
			dst[W/2-1:0] = '0;
			neg = dst[W-1];
			zero = (dst == '0);
			gt = ~neg & ~zero;
		end
		// clear forces a zero result whatever the operands hold
		if (op == dacc_pkg::DACC_CLR)
		begin
			dst = dacc_pkg::WORD_ZERO;
			dstg = '0;
			carry = 1'b0;
			ovf = 1'b0;
			neg = 1'b0;
			zero = 1'b1;
			gt = 1'b0;
		end
		// condition gate; compare has no conditional form
		uncond = (cform == dacc_pkg::DACC_UNCOND);
		case (cform)
			dacc_pkg::DACC_IF_TRUE: run = i_cond_flag_bit;
			dacc_pkg::DACC_IF_FALSE: run = ~i_cond_flag_bit;
			default: run = 1'b1;
		endcase
		// candidates for the condition flag; the select is applied outside
		o_cond_map_in = {carry, neg, zero, ovf, gt};
	end

	// next values of write-back and flag registers
	always_comb
	begin
		wr_en_nxt = (op != dacc_pkg::DACC_NONE) && (op != dacc_pkg::DACC_CMP) && run;
		dest_nxt = dz;
		data_nxt = dst;
		// guard write only for an accumulator, never on a conditional clear
		gwr_nxt = wr_en_nxt && (dz == dacc_pkg::DST_ACC_ZERO || dz == dacc_pkg::DST_ACC_ONE)
			&& (uncond || op != dacc_pkg::DACC_CLR);
		gdata_nxt = {{(32-GW){dstg[GW-1]}}, dstg};
		// a conditional form leaves every flag alone, even when it runs
		fwr_nxt = (op != dacc_pkg::DACC_NONE) && uncond;
		flags_nxt = flags_r;
		sel_nxt = sel_r;
		if (fwr_nxt)
		begin
			flags_nxt = {i_cond_map, neg, zero, ovf, gt};
			sel_nxt = i_cond_sel;
		end
	end

	// registers; one-cycle completion
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			wr_en_r <= 1'b0;
			gwr_r <= 1'b0;
			fwr_r <= 1'b0;
			dest_r <= '0;
			data_r <= '0;
			gdata_r <= '0;
			flags_r <= '0;
			sel_r <= '0;
		end
		else
		begin
			wr_en_r <= wr_en_nxt;
			gwr_r <= gwr_nxt;
			fwr_r <= fwr_nxt;
			dest_r <= dest_nxt;
			data_r <= data_nxt;
			gdata_r <= gdata_nxt;
			flags_r <= flags_nxt;
			sel_r <= sel_nxt;
		end
	end

	// outputs straight from the registers
	assign o_wr_en = wr_en_r;
	assign o_wr_dest = dest_r;
	assign o_wr_data = data_r;
	assign o_guard_wr_en = gwr_r;
	assign o_guard_data = gdata_r;
	assign o_flag_wr_en = fwr_r;
	assign {o_cond_flag_bit, o_negative_flag, o_zero_flag, o_overflow_flag, o_greater_flag} = flags_r;
	assign o_cond_sel_used = sel_r;
endmodule // dacc_alu

/* File: tb/dacc_cond_model.sv */
// model of the external condition-flag mapping
`timescale 1ns/1ns
module dacc_cond_model (
	// candidates {carry,neg,zero,ovf,gt} and select
	input wire logic [4:0] i_flags,
	input wire logic [2:0] i_sel,
	// chosen condition
	output logic o_map
);
	// select 0..4 picks carry..greater; spare codes read zero
	assign o_map = (i_sel < 3'h5) ? i_flags[3'h4 - i_sel] : 1'b0;
endmodule // dacc_cond_model

/* File: tb/dacc_alu_sva.sv */
// port checker for the alu stage
`timescale 1ns/1ns
module dacc_alu_sva #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// instruction and status in
	input wire logic i_valid,
	input wire logic [15:0] i_first_hw,
	input wire logic [15:0] i_second_hw,
	input wire logic [2:0] i_cond_sel,
	input wire logic i_cond_flag_bit,
	input wire logic i_cond_map,
	// results out
	input wire logic o_wr_en,
	input wire logic [W-1:0] o_wr_data,
	input wire logic o_guard_wr_en,
	input wire logic [31:0] o_guard_data,
	input wire logic o_flag_wr_en,
	input wire logic o_cond_flag_bit,
	input wire logic o_negative_flag,
	input wire logic o_zero_flag,
	input wire logic o_overflow_flag,
	input wire logic o_greater_flag,
	input wire logic [2:0] o_cond_sel_used
);
	// request taken and its opcode byte
	wire logic tk = i_valid && i_first_hw[15:10] == 6'h3e;
	wire logic [7:0] op = i_second_hw[15:8];
	wire logic clr = tk && op == 8'h8d && i_second_hw[7:4] == 4'h0;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	chk_clear_word: assert property (clr |=> o_wr_en && o_wr_data == '0)
		else $error("clear did not write zero");
	chk_clear_guard: assert property (clr && i_second_hw[3:1] == 3'h0
		|=> o_guard_wr_en && o_guard_data == '0)
		else $error("clear left guard");
	chk_clear_flags: assert property (clr |=> o_flag_wr_en && o_zero_flag && !o_negative_flag
		&& !o_overflow_flag && !o_greater_flag)
		else $error("clear flags wrong");
	chk_cond_map: assert property (clr |=> o_cond_flag_bit == $past(i_cond_map))
		else $error("cond flag not from mapping");
	chk_sel_used: assert property (tk && op == 8'h84 |=> o_cond_sel_used == $past(i_cond_sel))
		else $error("select not the prior value");
	chk_cond_flags: assert property (tk && op inside {8'h8e, 8'h8f, 8'hda, 8'hdb, 8'hfa, 8'hfb}
		|=> !o_flag_wr_en)
		else $error("conditional form touched flags");
	chk_cond_skip: assert property (tk && op == 8'h8e && !i_cond_flag_bit |=> !o_wr_en)
		else $error("unmatched form wrote");
	chk_cmp_only: assert property (tk && op == 8'h84 |=> !o_wr_en && o_flag_wr_en)
		else $error("compare wrote a register");
	chk_guard_ext: assert property (tk && op == 8'hda && i_cond_flag_bit && i_second_hw[3:1] == 3'h0
		|=> o_guard_wr_en && o_guard_data[31:8] == {24{o_guard_data[7]}})
		else $error("guard not sign extended");
endmodule // dacc_alu_sva
bind dacc_alu dacc_alu_sva #(.W(W)) i_sva (.i_mclk, .i_rst_n, .i_valid, .i_first_hw,
	.i_second_hw, .i_cond_sel, .i_cond_flag_bit, .i_cond_map, .o_wr_en, .o_wr_data,
	.o_guard_wr_en, .o_guard_data, .o_flag_wr_en, .o_cond_flag_bit, .o_negative_flag,
	.o_zero_flag, .o_overflow_flag, .o_greater_flag, .o_cond_sel_used);

/* File: tb/dacc_alu_test.sv */
// self-checking bench for the alu stage
`timescale 1ns/1ns
`define CHK(n, e, s) \
	compares++; \
	if ((s) !== (e)) \
	begin \
		error_cnt++; \
		$display("unexpected %s exp %h got %h", n, e, s); \
	end
module dacc_alu_test;
	logic i_mclk = 1'b0, i_rst_n = 1'b0, i_valid = 1'b0, dc = 1'b0, map;
	logic [15:0] hw2 = 16'h0000;
	logic [15:0] hw1 = 16'hf800;
	logic [2:0] sel = 3'h0;
	logic [31:0] x0 = 32'h2222_2222, y0 = 32'h3333_3333, m1 = 32'h8000_0000, a1 = 32'h0;
	logic [7:0] g1 = 8'h01;
	logic [4:0] cin;
	logic wr, gw, fw, cf, ng, zf, ov, gt;
	logic [3:0] dst;
	logic [31:0] wd, gd;
	logic [2:0] su;
	int error_cnt = 0, compares = 0;
	// clock, 8 ns period
	initial
	begin
		forever #4 i_mclk = ~i_mclk;
	end
	dacc_alu i_dut (.i_mclk, .i_rst_n, .i_valid, .i_first_hw(hw1), .i_second_hw(hw2),
		.i_xbus_reg_zero(x0), .i_xbus_reg_one(x0), .i_ybus_reg_zero(y0),
		.i_ybus_reg_one(32'h0), .i_mul_reg_zero(32'h0), .i_mul_reg_one(m1), .i_acc_zero(y0),
		.i_acc_one(a1), .i_acc_zero_guard(8'h00), .i_acc_one_guard(g1), .i_cond_sel(sel),
		.i_cond_flag_bit(dc), .i_cond_map(map), .o_cond_map_in(cin), .o_wr_en(wr),
		.o_wr_dest(dst), .o_wr_data(wd), .o_guard_wr_en(gw), .o_guard_data(gd),
		.o_flag_wr_en(fw), .o_cond_flag_bit(cf), .o_negative_flag(ng), .o_zero_flag(zf),
		.o_overflow_flag(ov), .o_greater_flag(gt), .o_cond_sel_used(su));
	dacc_cond_model i_map (.i_flags(cin), .i_sel(sel), .o_map(map));
	// one instruction; returns where its registered answer stands
	task automatic run(input logic [15:0] h);
		@(negedge i_mclk);
		hw2 = h;
		i_valid = 1'b1;
		@(negedge i_mclk);
		i_valid = 1'b0;
	endtask
	task automatic t_clear();
		sel = 3'h2;
		run(16'h8d00);
		`CHK("clr wr", {1'b1, 4'h0, 32'h0}, {wr, dst, wd})
		`CHK("clr guard", {1'b1, 32'h0}, {gw, gd})
		`CHK("clr flags", 6'b110100, {fw, cf, ng, zf, ov, gt})
		`CHK("clr sel", 3'h2, su)
		@(negedge i_mclk);
		`CHK("strobe", 2'b00, {wr, gw})
	endtask
	// both conditional clear forms against both flag values, dest acc_one
	task automatic t_cond();
		for (int i = 0; i < 4; i++)
		begin
			dc = i[0];
			run({7'h47, i[1], 8'h01});
			`CHK("cond wr", {dc ^ i[1], 2'b00}, {wr, gw, fw})
			`CHK("cond keep", 5'b10100, {cf, ng, zf, ov, gt})
		end
	endtask
	task automatic t_cmp();
		sel = 3'h1;
		run(16'h8400);
		`CHK("cmp a", 7'b0111000, {wr, fw, cf, ng, zf, ov, gt})
		`CHK("cmp sel", 3'h1, su)
		sel = 3'h4;
		run(16'h84f0);
		`CHK("cmp b", 7'b0110011, {wr, fw, cf, ng, zf, ov, gt})
	endtask
	task automatic t_copy();
		run(16'hd905);
		`CHK("cpy u", {5'h15, 32'h2222_2222, 7'b0110001}, {wr, dst, wd, gw, fw, cf, ng, zf, ov, gt})
		run(16'hf915);
		`CHK("cpy y", {5'h15, 32'h0, 6'b100100}, {wr, dst, wd, fw, cf, ng, zf, ov, gt})
		a1 = 32'h1234_5678;
		g1 = 8'h81;
		dc = 1'b1;
		run(16'hdac1);
		`CHK("cpy t", {1'b1, 32'h1234_5678, 1'b1, 32'hffff_ff81, 1'b0}, {wr, wd, gw, gd, fw})
		dc = 1'b0;
		run(16'hfb30);
		`CHK("cpy f", {5'h10, 32'h8000_0000, 1'b1, 32'hffff_ffff}, {wr, dst, wd, gw, gd})
	endtask
	// decrement from both operand sides, then an unmatched false form
	task automatic t_dec();
		run(16'h8905);
		`CHK("dec x", {5'h15, 32'h2221_0000, 5'b01001}, {wr, dst, wd, gw, fw, ng, zf, gt})
		run(16'ha935);
		`CHK("dec y", {5'h15, 32'h7fff_0000, 4'b1001}, {wr, dst, wd, fw, ng, zf, gt})
		dc = 1'b1;
		run(16'h8b05);
		`CHK("dec f", 3'b000, {wr, gw, fw})
	endtask
	// a bad first-halfword tag and an unknown opcode change nothing
	task automatic t_refuse();
		hw1 = 16'h7800;
		run(16'h8d00);
		`CHK("bad tag", 3'b000, {wr, gw, fw})
		hw1 = 16'hf800;
		run(16'h8000);
		`CHK("bad op", 3'b000, {wr, gw, fw})
	endtask
	task automatic finish_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#100000;
		error_cnt++;
		finish_test();
	end
	initial
	begin
		repeat (10) @(negedge i_mclk);
		i_rst_n = 1'b1;
		t_clear();
		t_cond();
		t_cmp();
		t_copy();
		t_dec();
		t_refuse();
		finish_test();
	end
endmodule // dacc_alu_test
